// *** pcg_pkg.sv ***
package pcg_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_LOOP_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_LOOP_BANDWIDTH = 8'h04;
	localparam logic [7:0] OFS_LOOP_RATIO     = 8'h08;

	// loop control field positions
	localparam int unsigned CTL_IRQ_ENABLE_BIT = 7;
	localparam int unsigned CTL_CHANGE_FLAG_BIT = 6;
	localparam int unsigned CTL_POWER_ON_BIT   = 5;
	localparam int unsigned CTL_BASE_SEL_BIT   = 4;
	localparam logic [3:0]  CTL_UNUSED_READ    = 4'hF;

	// bandwidth field positions
	localparam int unsigned BW_AUTO_BIT    = 7;
	localparam int unsigned BW_LOCK_BIT    = 6;
	localparam int unsigned BW_TRACK_BIT   = 5;
	localparam int unsigned BW_XTAL_LOSS_BIT = 4;
	localparam logic [3:0]  BW_TEST_READ   = 4'h0;

	// ratio field positions
	localparam int unsigned RATIO_MUL_LSB = 4;
	localparam int unsigned RATIO_VRS_LSB = 0;

	// values after reset, and the multiplier that code zero stands for
	localparam logic       RST_IRQ_ENABLE = 1'b0;
	localparam logic       RST_POWER_ON   = 1'b1;
	localparam logic       RST_BASE_SEL   = 1'b0;
	localparam logic       RST_AUTO       = 1'b0;
	localparam logic       RST_TRACK      = 1'b0;
	localparam logic [3:0] RST_MULTIPLIER = 4'h6;
	localparam logic [3:0] RST_VCO_RANGE  = 4'h6;
	localparam logic [3:0] MUL_ZERO_AS    = 4'h1;

	// clock switch: source edges waited per side, and a guard against a dead source
	localparam logic [1:0] SWITCH_EDGES      = 2'h3;
	localparam logic [5:0] SWITCH_GUARD_CYC  = 6'h3F;

	localparam int unsigned SYNC_W = 4;

	typedef struct packed {
		logic crystal_clock;
		logic vco_clock;
		logic lock_detect;
		logic track_status;
	} pcg_analog_in_t;

	typedef struct packed {
		logic       pll_enable;
		logic       auto_mode;
		logic       capture_track_bit;
		logic [3:0] feedback_multiplier;
		logic [3:0] vco_range_code;
	} pcg_pll_ctrl_t;

	typedef enum logic [1:0] {
		PCG_SW_RUN  = 2'b01,
		PCG_SW_HOLD = 2'b10
	} pcg_sw_state_t;

endpackage

// *** pcg_sync.sv ***
`timescale 1ns/1ps
module pcg_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					stage1[i] <= 1'b0;
					q[i]      <= 1'b0;
				end
				else
				begin
					stage1[i] <= d[i];
					q[i]      <= stage1[i];
				end
			end
		end
	endgenerate

endmodule

// *** pcg_clk_switch.sv ***
`timescale 1ns/1ps
module pcg_clk_switch (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic xclk_s,
	input  wire logic vclk_s,
	input  wire logic sel_vco,
	input  wire logic stop,
	output logic      base_clock_out
);

	pcg_pkg::pcg_sw_state_t state;
	logic       cur_sel;
	logic       xprev;
	logic       vprev;
	logic [1:0] xcnt;
	logic [1:0] vcnt;
	logic [5:0] guard;
	logic       xrise;
	logic       vrise;
	logic       src_rise;

	assign xrise    = xclk_s & ~xprev;
	assign vrise    = vclk_s & ~vprev;
	assign src_rise = cur_sel ? vrise : xrise;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			xprev <= 1'b0;
			vprev <= 1'b0;
		end
		else
		begin
			xprev <= xclk_s;
			vprev <= vclk_s;
		end
	end

	// output frozen while both sources run out their edges
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state   <= pcg_pkg::PCG_SW_RUN;
			cur_sel <= 1'b0;
			xcnt    <= 2'h0;
			vcnt    <= 2'h0;
			guard   <= 6'h00;
		end
		else
		begin
			case (state)
				pcg_pkg::PCG_SW_RUN:
				begin
					xcnt  <= 2'h0;
					vcnt  <= 2'h0;
					guard <= 6'h00;
					if (sel_vco != cur_sel)
						state <= pcg_pkg::PCG_SW_HOLD;
				end
				pcg_pkg::PCG_SW_HOLD:
				begin
					if (xrise && xcnt != pcg_pkg::SWITCH_EDGES)
						xcnt <= xcnt + 2'h1;
					if (vrise && vcnt != pcg_pkg::SWITCH_EDGES)
						vcnt <= vcnt + 2'h1;
					guard <= guard + 6'h01;
					// a stopped source must not hang the switch forever
					if ((xcnt == pcg_pkg::SWITCH_EDGES && vcnt == pcg_pkg::SWITCH_EDGES)
						|| guard == pcg_pkg::SWITCH_GUARD_CYC || stop)
					begin
						cur_sel <= sel_vco;
						state   <= pcg_pkg::PCG_SW_RUN;
					end
				end
				default:
					state <= pcg_pkg::PCG_SW_RUN;
			endcase
		end
	end

	// divide by two of the selected source, held low in stop
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			base_clock_out <= 1'b0;
		else if (stop)
			base_clock_out <= 1'b0;
		else if (state == pcg_pkg::PCG_SW_RUN && src_rise)
			base_clock_out <= ~base_clock_out;
	end

endmodule

// *** pcg_clock_gen_control.sv ***
`timescale 1ns/1ps
module pcg_clock_gen_control (
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	input  wire pcg_pkg::pcg_analog_in_t analog_in,
	input  wire logic                    stop_mode,
	input  wire logic                    break_state,
	input  wire logic                    break_clear_enable,
	output pcg_pkg::pcg_pll_ctrl_t       pll_ctrl,
	output logic                         crystal_clock_out,
	output logic                         base_clock_out,
	output logic                         loop_irq_out
);

	pcg_pkg::pcg_analog_in_t ana_s;

	logic       addr_take;
	logic       dph_pend;
	logic       dph_write;
	logic [7:0] dph_addr;
	logic       wr_ev;
	logic       rd_ev;
	logic       wr_ctl;
	logic       wr_bw;
	logic       wr_ratio;
	logic       rd_ctl;

	logic       lock_irq_enable;
	logic       lock_change_flag;
	logic       loop_power_on;
	logic       base_clock_select;
	logic       auto_mode;
	logic       lock_bit;
	logic       capture_track_bit;
	logic       crystal_loss_bit;
	logic [3:0] feedback_multiplier;
	logic [3:0] vco_range_code;

	logic       lock_toggle;
	logic       flag_clear;
	logic       range_zero;
	logic       xtal_prev;
	logic       xtal_edge;
	logic       track_rd;
	logic [7:0] loop_control_reg;
	logic [7:0] loop_bandwidth_reg;
	logic [7:0] loop_ratio_reg;
	logic       next_power_on;
	logic       next_base_sel;

	// every analog pin crosses two flops before use
	pcg_sync #(
		.W (pcg_pkg::SYNC_W)
	) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      (analog_in),
		.q      (ana_s)
	);

	pcg_clk_switch u_switch (
		.clk            (clk),
		.resetn         (resetn),
		.xclk_s         (ana_s.crystal_clock),
		.vclk_s         (ana_s.vco_clock),
		.sel_vco        (base_clock_select),
		.stop           (stop_mode),
		.base_clock_out (base_clock_out)
	);

	// bus slave: one wait state on every transfer so read data leave a flop
	assign addr_take = hsel & hready & htrans[1];
	assign wr_ev     = dph_pend & dph_write;
	assign rd_ev     = dph_pend & ~dph_write;
	assign wr_ctl    = wr_ev & (dph_addr == pcg_pkg::OFS_LOOP_CONTROL);
	assign wr_bw     = wr_ev & (dph_addr == pcg_pkg::OFS_LOOP_BANDWIDTH);
	assign wr_ratio  = wr_ev & (dph_addr == pcg_pkg::OFS_LOOP_RATIO);
	assign rd_ctl    = rd_ev & (dph_addr == pcg_pkg::OFS_LOOP_CONTROL);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dph_pend  <= 1'b0;
			dph_write <= 1'b0;
			dph_addr  <= 8'h00;
		end
		else
		begin
			dph_pend <= addr_take;
			if (addr_take)
			begin
				dph_write <= hwrite;
				dph_addr  <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= ~addr_take;
			hresp     <= 1'b0;
		end
	end

	// read views of the three registers
	assign track_rd = auto_mode ? ana_s.track_status : capture_track_bit;

	always_comb
	begin
		loop_control_reg = 8'h00;
		loop_control_reg[pcg_pkg::CTL_IRQ_ENABLE_BIT]  = lock_irq_enable & auto_mode;
		loop_control_reg[pcg_pkg::CTL_CHANGE_FLAG_BIT] = lock_change_flag & auto_mode;
		loop_control_reg[pcg_pkg::CTL_POWER_ON_BIT]    = loop_power_on;
		loop_control_reg[pcg_pkg::CTL_BASE_SEL_BIT]    = base_clock_select;
		loop_control_reg[3:0] = pcg_pkg::CTL_UNUSED_READ;
	end

	always_comb
	begin
		loop_bandwidth_reg = 8'h00;
		loop_bandwidth_reg[pcg_pkg::BW_AUTO_BIT]  = auto_mode;
		loop_bandwidth_reg[pcg_pkg::BW_LOCK_BIT]  = lock_bit;
		loop_bandwidth_reg[pcg_pkg::BW_TRACK_BIT] = track_rd;
		loop_bandwidth_reg[pcg_pkg::BW_XTAL_LOSS_BIT] = crystal_loss_bit & base_clock_select;
		// test bits are not built; they read as zero whatever software wrote
		loop_bandwidth_reg[3:0] = pcg_pkg::BW_TEST_READ;
	end

	always_comb
	begin
		loop_ratio_reg = 8'h00;
		loop_ratio_reg[pcg_pkg::RATIO_MUL_LSB +: 4] = feedback_multiplier;
		loop_ratio_reg[pcg_pkg::RATIO_VRS_LSB +: 4] = vco_range_code;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			hrdata <= 32'h0000_0000;
		else if (rd_ev)
		begin
			case (dph_addr)
				pcg_pkg::OFS_LOOP_CONTROL:   hrdata <= {24'h00_0000, loop_control_reg};
				pcg_pkg::OFS_LOOP_BANDWIDTH: hrdata <= {24'h00_0000, loop_bandwidth_reg};
				pcg_pkg::OFS_LOOP_RATIO:     hrdata <= {24'h00_0000, loop_ratio_reg};
				default:                     hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// automatic bandwidth mode select
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			auto_mode <= pcg_pkg::RST_AUTO;
		else if (wr_bw)
			auto_mode <= hwdata[pcg_pkg::BW_AUTO_BIT];
	end

	// lock indicator only follows the detector in automatic mode
	assign lock_toggle = auto_mode & (ana_s.lock_detect != lock_bit);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			lock_bit <= 1'b0;
		else
			lock_bit <= auto_mode & ana_s.lock_detect;
	end

	// manual value survives untouched through automatic mode
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			capture_track_bit <= pcg_pkg::RST_TRACK;
		else if (wr_bw && !auto_mode)
			capture_track_bit <= hwdata[pcg_pkg::BW_TRACK_BIT];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			lock_irq_enable <= pcg_pkg::RST_IRQ_ENABLE;
		else if (wr_ctl && auto_mode)
			lock_irq_enable <= hwdata[pcg_pkg::CTL_IRQ_ENABLE_BIT];
	end

	// a break with clearing disabled protects the flag from debugger reads
	assign flag_clear = rd_ctl & ~(break_state & ~break_clear_enable);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			lock_change_flag <= 1'b0;
		else if (lock_toggle)
			lock_change_flag <= 1'b1;
		else if (flag_clear)
			lock_change_flag <= 1'b0;
	end

	// power and source interlocks judge the old values, so one write cannot do both
	assign range_zero    = (vco_range_code == 4'h0);
	assign next_power_on = hwdata[pcg_pkg::CTL_POWER_ON_BIT] | base_clock_select;
	assign next_base_sel = hwdata[pcg_pkg::CTL_BASE_SEL_BIT] & loop_power_on
		& ~range_zero;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			loop_power_on <= pcg_pkg::RST_POWER_ON;
		else if (wr_ctl)
			loop_power_on <= next_power_on;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			base_clock_select <= pcg_pkg::RST_BASE_SEL;
		else if (stop_mode || range_zero)
			base_clock_select <= 1'b0;
		else if (wr_ctl)
			base_clock_select <= next_base_sel;
	end

	// crystal loss: while base_clock_select is set a write of one arms the bit, a crystal edge in a later cycle clears it
	assign xtal_edge = ana_s.crystal_clock & ~xtal_prev;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			xtal_prev <= 1'b0;
		else
			xtal_prev <= ana_s.crystal_clock;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			crystal_loss_bit <= 1'b0;
		else if (!base_clock_select)
			crystal_loss_bit <= 1'b0;
		else if (wr_bw && hwdata[pcg_pkg::BW_XTAL_LOSS_BIT])
			crystal_loss_bit <= 1'b1;
		else if (xtal_edge)
			crystal_loss_bit <= 1'b0;
	end

	// ratio nibbles locked while the loop is powered
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			feedback_multiplier <= pcg_pkg::RST_MULTIPLIER;
			vco_range_code      <= pcg_pkg::RST_VCO_RANGE;
		end
		else if (wr_ratio && !loop_power_on)
		begin
			feedback_multiplier <= hwdata[pcg_pkg::RATIO_MUL_LSB +: 4];
			vco_range_code      <= hwdata[pcg_pkg::RATIO_VRS_LSB +: 4];
		end
	end

	// outputs to the analog loop
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pll_ctrl.pll_enable          <= 1'b0;
			pll_ctrl.auto_mode           <= pcg_pkg::RST_AUTO;
			pll_ctrl.capture_track_bit   <= pcg_pkg::RST_TRACK;
			pll_ctrl.feedback_multiplier <= pcg_pkg::RST_MULTIPLIER;
			pll_ctrl.vco_range_code      <= pcg_pkg::RST_VCO_RANGE;
		end
		else
		begin
			pll_ctrl.pll_enable <= loop_power_on & ~range_zero & ~stop_mode;
			pll_ctrl.auto_mode  <= auto_mode;
			pll_ctrl.capture_track_bit <= capture_track_bit;
			if (feedback_multiplier == 4'h0)
				pll_ctrl.feedback_multiplier <= pcg_pkg::MUL_ZERO_AS;
			else
				pll_ctrl.feedback_multiplier <= feedback_multiplier;
			pll_ctrl.vco_range_code <= vco_range_code;
		end
	end

	// wait mode needs nothing here: the generator simply keeps running
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			crystal_clock_out <= 1'b0;
		else
			crystal_clock_out <= ana_s.crystal_clock & ~stop_mode;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			loop_irq_out <= 1'b0;
		else
			loop_irq_out <= lock_change_flag & lock_irq_enable & auto_mode
				& ~stop_mode;
	end

endmodule

// *** pcg_properties.sv ***
`timescale 1ns/1ps
module pcg_properties (
	input wire logic                    clk,
	input wire logic                    resetn,
	input wire pcg_pkg::pcg_analog_in_t analog_in,
	input wire logic                    stop_mode,
	input wire pcg_pkg::pcg_pll_ctrl_t  pll_ctrl,
	input wire logic                    crystal_clock_out,
	input wire logic                    base_clock_out,
	input wire logic                    loop_irq_out
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_stop_irq_low: assert property (stop_mode |=> !loop_irq_out)
		else $error("interrupt output high after stop");
	a_stop_base_low: assert property (stop_mode |=> !base_clock_out)
		else $error("base clock high after stop");
	a_stop_xtal_low: assert property (stop_mode |=> !crystal_clock_out)
		else $error("crystal clock output high after stop");
	a_stop_loop_off: assert property (stop_mode |=> !pll_ctrl.pll_enable)
		else $error("loop enabled during stop");
	a_manual_no_irq: assert property (!pll_ctrl.auto_mode ##1 !pll_ctrl.auto_mode |-> !loop_irq_out)
		else $error("interrupt raised in manual mode");
	a_irq_needs_auto: assert property (loop_irq_out |-> pll_ctrl.auto_mode || $past(pll_ctrl.auto_mode))
		else $error("interrupt without self-control");
	a_range_zero_off: assert property ((pll_ctrl.vco_range_code == 4'h0)[*2] |-> !pll_ctrl.pll_enable)
		else $error("loop enabled with range zero");
	a_mul_not_zero: assert property (pll_ctrl.feedback_multiplier != 4'h0)
		else $error("multiplier code zero passed on");
	a_ratio_held: assert property (pll_ctrl.pll_enable[*2] |->
		$stable(pll_ctrl.feedback_multiplier) && $stable(pll_ctrl.vco_range_code))
		else $error("ratio changed while loop on");
	// sync flops start from reset, so only compare once four sampled edges are out of reset
	a_xtal_follows: assert property ((resetn && !stop_mode)[*4] |->
		crystal_clock_out == $past(analog_in.crystal_clock, 3))
		else $error("crystal clock output not following pin");
endmodule

// *** pcg_analog_model.sv ***
`timescale 1ns/1ps
module pcg_analog_model (
	input  wire logic               pll_on,
	input  wire logic               xtal_run,
	input  wire logic               lock_cmd,
	input  wire logic               track_cmd,
	output pcg_pkg::pcg_analog_in_t ana
);
	logic xc = 1'b0;
	logic vc = 1'b0;
	// half periods never land on a rising clk edge, and stay far below clk/4
	initial forever #440 xc = xtal_run & ~xc;
	initial forever #640 vc = pll_on & ~vc;
	assign ana = '{xc, vc, lock_cmd & pll_on, track_cmd};
endmodule

// *** pcg_tb.sv ***
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] CTL = pcg_pkg::OFS_LOOP_CONTROL;
	localparam logic [7:0] BW = pcg_pkg::OFS_LOOP_BANDWIDTH;
	localparam logic [7:0] RAT = pcg_pkg::OFS_LOOP_RATIO;
	logic                    clk;
	logic                    resetn;
	logic                    hsel;
	logic [31:0]             haddr;
	logic [1:0]              htrans;
	logic                    hwrite;
	logic [2:0]              hsize;
	logic [31:0]             hwdata;
	logic                    hreadyout;
	logic                    hresp;
	logic [31:0]             hrdata;
	pcg_pkg::pcg_analog_in_t analog_in;
	logic                    stop_mode;
	logic                    break_state;
	logic                    break_clear_enable;
	pcg_pkg::pcg_pll_ctrl_t  pll_ctrl;
	logic                    crystal_clock_out;
	logic                    base_clock_out;
	logic                    loop_irq_out;
	logic                    xtal_run;
	logic                    lock_cmd;
	logic                    track_cmd;
	int                      n_mismatch;
	int                      n_compared;
	int                      seed;
	logic [7:0]              rv;

	pcg_clock_gen_control dut_u (
		.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analog_in(analog_in),
		.stop_mode(stop_mode), .break_state(break_state),
		.break_clear_enable(break_clear_enable), .pll_ctrl(pll_ctrl),
		.crystal_clock_out(crystal_clock_out), .base_clock_out(base_clock_out),
		.loop_irq_out(loop_irq_out)
	);
	pcg_analog_model pll_u (
		.pll_on(pll_ctrl.pll_enable), .xtal_run(xtal_run), .lock_cmd(lock_cmd),
		.track_cmd(track_cmd), .ana(analog_in)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] ctl_val(input logic [3:0] f);
		return {24'h0, f, 4'hF};
	endfunction
	function automatic logic [3:0] mul_eff(input logic [3:0] m);
		return (m == 4'h0) ? 4'h1 : m;
	endfunction

	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, d, output logic [31:0] r);
		int t;
		t = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1 && ++t < 20);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1 && ++t < 20);
		r = hrdata;
		if (t >= 20)
			n_mismatch++;
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		chk(r, e);
	endtask
	// base clock toggles once per rising edge of its source; allow one edge of sync skew
	task automatic base_rate(input logic vco);
		int src;
		int tog;
		logic ps;
		logic pb;
		logic cur;
		src = 0;
		tog = 0;
		repeat (80) @(posedge clk);
		ps = vco ? analog_in.vco_clock : analog_in.crystal_clock;
		pb = base_clock_out;
		repeat (300)
		begin
			@(posedge clk);
			cur = vco ? analog_in.vco_clock : analog_in.crystal_clock;
			src += int'(cur && !ps);
			tog += int'(pb != base_clock_out);
			ps = cur;
			pb = base_clock_out;
		end
		chk(32'(tog > src - 2 && tog < src + 2 && src > 10), 32'h1);
	endtask
	task automatic final_report;
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		n_mismatch = 0;
		n_compared = 0;
		seed = 32'h008F;
		{hsel, hwrite, stop_mode, break_state, break_clear_enable, lock_cmd, track_cmd} = '0;
		haddr = '0;
		htrans = 2'b00;
		hsize = 3'h2;
		hwdata = '0;
		xtal_run = 1'b1;
		resetn = 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(CTL, ctl_val(4'b0010));
		rd(BW, 32'h0);
		rd(RAT, 32'h66);
		chk(32'(pll_ctrl.feedback_multiplier), 32'h6);
		wr(8'h0C, 8'hFF);
		rd(8'h0C, 32'h0);
		wr(RAT, 8'h12);
		rd(RAT, 32'h66);
		wr(CTL, 8'h00);
		rd(CTL, ctl_val(4'b0000));
		for (int i = 0; i < 6; i++)
		begin
			rv = (i == 0) ? 8'h0A : 8'($random(seed));
			wr(RAT, rv);
			rd(RAT, {24'h0, rv});
			chk(32'(pll_ctrl.feedback_multiplier), 32'(mul_eff(rv[7:4])));
			chk(32'(pll_ctrl.vco_range_code), 32'(rv[3:0]));
		end
		wr(RAT, 8'h50);
		wr(CTL, 8'h20);
		wr(CTL, 8'h30);
		rd(CTL, ctl_val(4'b0010));
		chk(32'(pll_ctrl.pll_enable), 32'h0);
		wr(CTL, 8'h00);
		wr(RAT, 8'h66);
		wr(CTL, 8'h30);
		rd(CTL, ctl_val(4'b0010));
		wr(CTL, 8'h30);
		rd(CTL, ctl_val(4'b0011));
		wr(CTL, 8'h10);
		rd(CTL, ctl_val(4'b0011));
		base_rate(1'b1);
		wr(BW, 8'h10);
		repeat (24) @(posedge clk);
		rd(BW, 32'h0);
		xtal_run <= 1'b0;
		repeat (10) @(posedge clk);
		wr(BW, 8'h10);
		repeat (24) @(posedge clk);
		rd(BW, 32'h10);
		xtal_run <= 1'b1;
		// let a fresh crystal edge pass the sync so the armed loss bit is cleared
		repeat (12) @(posedge clk);
		wr(BW, 8'h20);
		rd(BW, 32'h20);
		wr(CTL, 8'hB0);
		rd(CTL, ctl_val(4'b0011));
		lock_cmd <= 1'b1;
		repeat (8) @(posedge clk);
		rd(CTL, ctl_val(4'b0011));
		wr(BW, 8'hA0);
		rd(BW, 32'hC0);
		wr(CTL, 8'hB0);
		repeat (3) @(posedge clk);
		chk(32'(loop_irq_out), 32'h1);
		break_state <= 1'b1;
		rd(CTL, ctl_val(4'b1111));
		rd(CTL, ctl_val(4'b1111));
		break_clear_enable <= 1'b1;
		rd(CTL, ctl_val(4'b1111));
		rd(CTL, ctl_val(4'b1011));
		chk(32'(loop_irq_out), 32'h0);
		break_state <= 1'b0;
		track_cmd <= 1'b1;
		lock_cmd <= 1'b0;
		repeat (8) @(posedge clk);
		rd(BW, 32'hA0);
		rd(CTL, ctl_val(4'b1111));
		wr(CTL, 8'h30);
		lock_cmd <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'(loop_irq_out), 32'h0);
		rd(CTL, ctl_val(4'b0111));
		wr(CTL, 8'hB0);
		wr(BW, 8'h00);
		rd(BW, 32'h20);
		chk(32'(pll_ctrl.capture_track_bit), 32'h1);
		rd(CTL, ctl_val(4'b0011));
		stop_mode <= 1'b1;
		repeat (20) @(posedge clk);
		stop_mode <= 1'b0;
		@(posedge clk);
		rd(CTL, ctl_val(4'b0010));
		xtal_run <= 1'b0;
		repeat (10) @(posedge clk);
		wr(BW, 8'h30);
		rd(BW, 32'h20);
		xtal_run <= 1'b1;
		base_rate(1'b0);
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
endmodule

bind pcg_clock_gen_control pcg_properties chk_u (
	.clk(clk), .resetn(resetn), .analog_in(analog_in), .stop_mode(stop_mode),
	.pll_ctrl(pll_ctrl), .crystal_clock_out(crystal_clock_out),
	.base_clock_out(base_clock_out), .loop_irq_out(loop_irq_out)
);
